// [src/acc_defs.svh]
/*
 * Register offsets, field positions, reset values and timing counts for the
 * converter control block.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets (special function register space)
// ----------------------------------------------------------------------------
`define ACC_OFS_PRESCALER     8'hf2
`define ACC_OFS_CONTROL       8'hf3
`define ACC_OFS_RESULT_LOW    8'hf4
`define ACC_OFS_RESULT_HIGH   8'hf5
`define ACC_OFS_PIN_CONFIG    8'hf6

// ----------------------------------------------------------------------------
// control and prescaler register fields
// ----------------------------------------------------------------------------
`define ACC_BIT_QUIET         6
`define ACC_BIT_ENABLE        5
`define ACC_BIT_DONE          4
`define ACC_BIT_START         3
`define ACC_CH_HI             2
`define ACC_CH_LO             0
`define ACC_PRS_HI            4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACC_RST_BYTE          8'h00
`define ACC_RST_RESULT        10'h000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define ACC_CONV_TICKS        4'hb
`define ACC_ZERO_DIV          7'h40
`define ACC_DIV_W             7

`endif

// [src/acc_pkg.sv]
/*
 * Types shared by the converter control block and its helpers.
 * Assumes acc_defs.svh is on the include path.
 */
`include "acc_defs.svh"

package acc_pkg;

   // -------------------------------------------------------------------------
   // register bus access
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acc_sfr_req_t;

   // -------------------------------------------------------------------------
   // converter interface
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic       powered;
      logic       sample;
      logic [2:0] channel;
   } acc_analog_ctl_t;

   typedef enum logic [1:0] {
      ACC_IDLE   = 2'b00,
      ACC_SAMPLE = 2'b01,
      ACC_CONV   = 2'b11
   } acc_state_t;

endpackage : acc_pkg

// [src/acc_tick_gen.sv]
/*
 * Converter clock tick generator: one-cycle tick per converter clock period.
 * Assumes the prescaler value is stable during a conversion.
 */
`timescale 1ns/1ns
`include "acc_defs.svh"

module acc_tick_gen
   import acc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       run,
   input  wire logic [4:0] divider,
   input  wire logic       double_speed_mode,
   output logic            tick
);

   typedef struct packed {
      logic [`ACC_DIV_W-1:0] cnt;
      logic                  tick;
   } acc_tick_state_t;

   acc_tick_state_t s_q;
   acc_tick_state_t s_d;

   // -------------------------------------------------------------------------
   // period in peripheral clocks
   // -------------------------------------------------------------------------
   function automatic logic [`ACC_DIV_W-1:0] period(input logic [4:0] prs, input logic x2);
      if (prs == 5'h00) begin
         period = `ACC_ZERO_DIV;
      end else if (x2) begin
         period = {1'b0, prs, 1'b0};
      end else begin
         period = {prs, 2'b00};
      end
   endfunction : period

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.cnt = '0;
      // RULE8 prescaled divide
      // RULE17 zero means sixty-four
      end else if (s_q.cnt >= period(divider, double_speed_mode) - 7'h01) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 7'h01;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : acc_tick_gen

// [src/acc_sequencer.sv]
/*
 * Conversion sequencer: one sample tick, then ten bit ticks.
 * Assumes ticks come from acc_tick_gen and the analog result is settled
 * when the last tick arrives.
 */
`timescale 1ns/1ns
`include "acc_defs.svh"

module acc_sequencer
   import acc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       launch,
   input  wire logic       tick,
   output acc_state_t      state,
   output logic            done
);

   typedef struct packed {
      acc_state_t st;
      logic [3:0] left;
      logic       done;
   } acc_seq_state_t;

   acc_seq_state_t s_q;
   acc_seq_state_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         ACC_IDLE: begin
            if (launch) begin
               s_d.st   = ACC_SAMPLE;
               s_d.left = `ACC_CONV_TICKS;
            end
         end
         // RULE18 eleven converter clocks
         ACC_SAMPLE, ACC_CONV: begin
            if (tick) begin
               s_d.left = s_q.left - 4'h1;
               s_d.st   = ACC_CONV;
               if (s_q.left == 4'h1) begin
                  s_d.st   = ACC_IDLE;
                  s_d.done = 1'b1;
               end
            end
         end
         default: s_d.st = ACC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '{st: ACC_IDLE, left: 4'h0, done: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign state = s_q.st;
   assign done  = s_q.done;

endmodule : acc_sequencer

// [src/acc_conv_ctrl.sv]
/*
 * Conversion control for a ten-bit, eight-input converter behind special
 * function registers: pin routing, channel select, enable, start/busy,
 * end flag, quiet-core mode, prescaler and split result registers.
 * Assumes a single-cycle register port on clk, the analog result arriving
 * from a pin-side converter (synchronised here), and an interrupt
 * controller outside that owns enables and priority.
 */
// Contract
// RULE1 - pin config bits route pins to analog
// RULE2 - bit six quiets core during conversion
// RULE3 - bit five enables, clear means standby
// RULE4 - done flag set by hardware, software clears
// RULE5 - start bit starts, stays busy, self-clears
// RULE6 - bits two to zero pick channel
// RULE7 - reserved bits: software writes zeros
// RULE8 - prescaler divides by four or two times
// RULE9 - high result holds bits nine to two
// RULE10 - low result holds bits one, zero
// RULE11 - software joins high shifted plus low
// RULE12 - software masks channel before merging new
// RULE13 - standard start: start bit, quiet clear
// RULE14 - precision start: quiet and start together
// RULE15 - software enables converter and global interrupts
// RULE16 - codes zero to seven select inputs
// RULE17 - zero prescaler divides by sixty-four
// RULE18 - conversion takes eleven converter clocks
// RULE19 - start on unrouted pin does nothing
// RULE20 - restart while busy is ignored
// RULE21 - results update together at completion
`timescale 1ns/1ns
`include "acc_defs.svh"

module acc_conv_ctrl
   import acc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  acc_sfr_req_t    sfr_req,
   output logic [7:0]      sfr_rdata,
   input  wire logic       double_speed_mode,
   input  wire logic [9:0] analog_result,
   output logic [7:0]      analog_pin_select,
   output logic [7:0]      selected_analog_input,
   output acc_analog_ctl_t analog_ctl,
   output logic            quiet_core,
   output logic            conv_irq_request
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  pin_cfg;
      logic [4:0]  prs;
      logic        quiet;
      logic        enable;
      logic        done_flag;
      logic        busy;
      logic [2:0]  channel;
      logic [9:0]  result;
      logic [9:0]  ain_meta;
      logic [9:0]  ain_sync;
      logic        x2_meta;
      logic        x2_sync;
      logic [7:0]  rdata;
      logic [7:0]  pin_sel;
      logic [7:0]  mux_sel;
      acc_analog_ctl_t actl;
      logic        quiet_out;
   } acc_ctrl_state_t;

   acc_ctrl_state_t s_q;
   acc_ctrl_state_t s_d;

   acc_state_t seq_state;
   logic       tick;
   logic       seq_done;
   logic       launch;

   // RULE16 one-hot decode of channel code
   function automatic logic [7:0] one_hot(input logic [2:0] code);
      one_hot = 8'h01 << code;
   endfunction : one_hot

   function automatic logic hit(input acc_sfr_req_t r, input logic [7:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction : hit

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   acc_tick_gen i_acc_tick_gen (
      .clk               (clk),
      .reset             (reset),
      .run               (s_q.busy),
      .divider           (s_q.prs),
      .double_speed_mode (s_q.x2_sync),
      .tick              (tick)
   );

   acc_sequencer i_acc_sequencer (
      .clk    (clk),
      .reset  (reset),
      .launch (launch),
      .tick   (tick),
      .state  (seq_state),
      .done   (seq_done)
   );

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      s_d    = s_q;
      launch = 1'b0;

      // pin-side inputs pass two flops before use
      s_d.ain_meta = analog_result;
      s_d.ain_sync = s_q.ain_meta;
      s_d.x2_meta  = double_speed_mode;
      s_d.x2_sync  = s_q.x2_meta;

      // RULE1 pin routing register
      if (hit(sfr_req, `ACC_OFS_PIN_CONFIG)) begin
         s_d.pin_cfg = sfr_req.wdata;
      end
      // RULE8 prescaler write
      if (hit(sfr_req, `ACC_OFS_PRESCALER)) begin
         s_d.prs = sfr_req.wdata[`ACC_PRS_HI:0];
      end

      if (hit(sfr_req, `ACC_OFS_CONTROL)) begin
         // RULE2 quiet mode bit
         s_d.quiet   = sfr_req.wdata[`ACC_BIT_QUIET];
         // RULE3 enable or standby
         s_d.enable  = sfr_req.wdata[`ACC_BIT_ENABLE];
         // RULE6 channel field; frozen while busy to protect the sample
         if (!s_q.busy) begin
            s_d.channel = sfr_req.wdata[`ACC_CH_HI:`ACC_CH_LO];
         end
         // RULE4 software may only clear the flag
         if (!sfr_req.wdata[`ACC_BIT_DONE]) begin
            s_d.done_flag = 1'b0;
         end
         // RULE5 start when idle
         // RULE19 channel pin must be routed
         // RULE20 ignored while busy
         if (sfr_req.wdata[`ACC_BIT_START] && !s_q.busy
             && sfr_req.wdata[`ACC_BIT_ENABLE]
             && (s_q.pin_cfg & one_hot(sfr_req.wdata[`ACC_CH_HI:`ACC_CH_LO])) != 8'h00) begin
            s_d.busy = 1'b1;
            launch   = 1'b1;
         end
      end

      // RULE5 hardware clears busy at completion
      // RULE4 set wins over a same-cycle clear
      // RULE21 both bytes latched together
      if (seq_done) begin
         s_d.busy      = 1'b0;
         s_d.done_flag = 1'b1;
         s_d.result    = s_q.ain_sync;
      end

      // RULE7 reserved bits read as zero
      // RULE9 high byte bits nine to two
      // RULE10 low byte bits one and zero
      unique case (sfr_req.addr)
         `ACC_OFS_PRESCALER:   s_d.rdata = {3'h0, s_q.prs};
         `ACC_OFS_CONTROL:     s_d.rdata = {1'b0, s_q.quiet, s_q.enable, s_q.done_flag,
                                            s_q.busy, s_q.channel};
         `ACC_OFS_RESULT_LOW:  s_d.rdata = {6'h00, s_q.result[1:0]};
         `ACC_OFS_RESULT_HIGH: s_d.rdata = s_q.result[9:2];
         `ACC_OFS_PIN_CONFIG:  s_d.rdata = s_q.pin_cfg;
         default:              s_d.rdata = `ACC_RST_BYTE;
      endcase
      if (!sfr_req.rd) begin
         s_d.rdata = `ACC_RST_BYTE;
      end

      s_d.pin_sel      = s_q.pin_cfg;
      s_d.mux_sel      = one_hot(s_q.channel) & s_q.pin_cfg;
      s_d.actl.powered = s_q.enable;
      s_d.actl.sample  = (seq_state == ACC_SAMPLE);
      s_d.actl.channel = s_q.channel;
      // RULE2 hold core only while a quiet conversion runs
      // registered busy keeps it in step with the sample output
      s_d.quiet_out    = s_q.quiet && s_q.busy;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------------------
   // outputs, all from flops
   // -------------------------------------------------------------------------
   assign sfr_rdata             = s_q.rdata;
   assign analog_pin_select     = s_q.pin_sel;
   assign selected_analog_input = s_q.mux_sel;
   assign analog_ctl            = s_q.actl;
   assign quiet_core            = s_q.quiet_out;
   // RULE4 interrupt request follows the flag
   assign conv_irq_request      = s_q.done_flag;

endmodule : acc_conv_ctrl

// [dv/acc_conv_ctrl_assertions.sv]
/* port checker for the conversion control block
   bound onto every acc_conv_ctrl instance */
`timescale 1ns/1ns
module acc_conv_ctrl_assertions
   import acc_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input acc_sfr_req_t    sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] analog_pin_select,
   input wire logic [7:0] selected_analog_input,
   input acc_analog_ctl_t analog_ctl,
   input wire logic       quiet_core,
   input wire logic       conv_irq_request
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic       clr;
   logic [9:0] since_q;
   assign clr = sfr_req.wr && sfr_req.addr == 8'hf3 && !sfr_req.wdata[4];
   // saturating count since the sample slot
   always_ff @(posedge clk or posedge reset) begin
      if (reset) since_q <= 10'h000;
      else if (analog_ctl.sample) since_q <= 10'h000;
      else if (since_q != 10'h3ff) since_q <= since_q + 10'h001;
   end
   a_unmapped_rd: assert property (sfr_req.rd && (sfr_req.addr < 8'hf2 ||
      sfr_req.addr > 8'hf6) |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   a_ctl_reserved: assert property (sfr_req.rd && sfr_req.addr == 8'hf3
      |=> !sfr_rdata[7]) else $error("control bit 7 set");
   a_low_reserved: assert property (sfr_req.rd && sfr_req.addr == 8'hf4
      |=> sfr_rdata[7:2] == 6'h00) else $error("low result upper bits set");
   a_pin_copy: assert property (sfr_req.wr && sfr_req.addr == 8'hf6
      |-> ##2 analog_pin_select == $past(sfr_req.wdata, 2)) else $error("pin routing wrong");
   a_power_bit: assert property (sfr_req.wr && sfr_req.addr == 8'hf3
      |-> ##2 analog_ctl.powered == $past(sfr_req.wdata[5], 2)) else $error("enable wrong");
   a_standby_idle: assert property (!analog_ctl.powered
      |-> !analog_ctl.sample && !quiet_core) else $error("activity in standby");
   a_flag_clear: assert property ($fell(conv_irq_request)
      |-> $past(clr) || $past(clr, 2)) else $error("flag dropped by itself");
   a_conv_len: assert property ($rose(conv_irq_request)
      |-> since_q >= 10'd16 && since_q <= 10'd800) else $error("conversion length off");
   a_sel_onehot: assert property ($onehot0(selected_analog_input))
      else $error("more than one input routed");
   a_chan_hold: assert property (quiet_core ##1 quiet_core
      |-> $stable(analog_ctl.channel)) else $error("channel moved while busy");
   c_done: cover property ($rose(conv_irq_request));
   c_quiet: cover property ($rose(quiet_core));
   c_high_rd: cover property (sfr_req.rd && sfr_req.addr == 8'hf5);
endmodule : acc_conv_ctrl_assertions

bind acc_conv_ctrl acc_conv_ctrl_assertions i_acc_conv_ctrl_assertions (
   .clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .analog_pin_select(analog_pin_select), .selected_analog_input(selected_analog_input),
   .analog_ctl(analog_ctl), .quiet_core(quiet_core), .conv_irq_request(conv_irq_request));

// [dv/acc_analog_model.sv]
/* behavioural pin-side converter: one fixed level per input
   assumes levels hold still during a conversion */
`timescale 1ns/1ns
module acc_analog_model
   import acc_pkg::*;
(
   input  wire logic        clk,
   input  acc_analog_ctl_t  analog_ctl,
   input  wire logic [79:0] levels,
   output logic [9:0]       analog_result
);
   logic [9:0] junk_q = 10'h2aa;
   // standby output changes every cycle, never a usable value
   always @(posedge clk) junk_q <= ~junk_q;
   // code picks input, standby gives junk
   assign analog_result = analog_ctl.powered ? levels[analog_ctl.channel*10 +: 10] : junk_q;
endmodule : acc_analog_model

// [dv/tb_adc_conversion_control.sv]
/* self-checking bench for acc_conv_ctrl with a converter model
   assumes the checker is bound in from its own file */
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_adc_conversion_control;
   import acc_pkg::*;
   logic clk = 0, reset = 1, ds = 0, pend = 0, quiet, irq;
   acc_sfr_req_t req = '0;
   acc_analog_ctl_t actl;
   logic [7:0] rdata, ctl, sel, pins, ev;
   logic [9:0] ares, r;
   logic [79:0] lev = '0;
   logic [7:0] exq[$];
   int mismatches = 0, total_checks = 0, cyc = 0, n, p;
   always #5 clk = ~clk;
   acc_conv_ctrl i_acc_conv_ctrl (.clk(clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata),
      .double_speed_mode(ds), .analog_result(ares), .analog_pin_select(pins),
      .selected_analog_input(sel), .analog_ctl(actl), .quiet_core(quiet),
      .conv_irq_request(irq));
   acc_analog_model i_acc_analog_model (.clk(clk), .analog_ctl(actl), .levels(lev),
      .analog_result(ares));
   // ------------------------------------------------------------
   // bus tasks and read monitor
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr <= 1'b1; req.addr <= a; req.wdata <= d;
      @(posedge clk); req.wr <= 1'b0; @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exq.push_back(e); req.rd <= 1'b1; req.addr <= a;
      @(posedge clk); req.rd <= 1'b0; @(posedge clk);
   endtask : rd
   always @(posedge clk) begin
      if (pend) begin
         ev = exq.pop_front();
         `CHK(rdata, ev)
      end
      pend <= req.rd;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin mismatches++; give_verdict(); end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      n = $urandom(32'hfa577072);
      lev = {$urandom(), $urandom(), 16'($urandom())};
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++) rd(8'hf2 + 8'(i), 8'h00);
      rd(8'hf7, 8'h00);
      wr(8'hf6, 8'h7f); rd(8'hf6, 8'h7f);
      wr(8'hf3, 8'h08); rd(8'hf3, 8'h00);
      wr(8'hf3, 8'h2f); rd(8'hf3, 8'h27);
      for (int i = 0; i < 8; i++) begin
         ds <= i[0];
         p = (i == 7) ? 64 : (i[0] ? 2 : 4);
         r = lev[i*10 +: 10];
         if (i == 7) wr(8'hf6, 8'hff);
         wr(8'hf2, {7'h00, i != 7}); rd(8'hf2, {7'h00, i != 7});
         // clear the field, merge the code
         ctl = (8'h20 & 8'hf8) | 8'h08 | {1'b0, i[1], 3'b000, 3'(i)};
         wr(8'hf3, ctl);
         // select and quiet outputs are one flop behind the start
         @(posedge clk);
         `CHK(sel, 8'h01 << i)
         `CHK(quiet, i[1])
         rd(8'hf3, ctl);
         wr(8'hf3, ctl ^ 8'h01);
         n = 0;
         while (irq !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
         `CHK(n + 6 >= 11 * p && n + 6 <= 11 * p + 3, 1'b1)
         rd(8'hf3, (ctl & 8'hf7) | 8'h10);
         `CHK(quiet, 1'b0)
         rd(8'hf5, r[9:2]); rd(8'hf4, {6'h00, r[1:0]});
         wr(8'hf5, 8'h5a); rd(8'hf5, r[9:2]);
         wr(8'hf3, 8'h20 | 8'(i)); rd(8'hf3, 8'h20 | 8'(i));
         `CHK(irq, 1'b0)
         rd(8'hf5, r[9:2]);
      end
      give_verdict();
   end
endmodule : tb_adc_conversion_control
